// ==== logic/icfg_pkg.sv ====
// Package for the two-wire configuration slave: address, register map, reset values.
// Assumes a single system clock domain; the link pins are sampled, not clocked on.
package icfg_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h70;
  localparam int NUM_REGS = 8;
  localparam logic [7:0] LAST_SUB = 8'h07;
  localparam logic [7:0] SUB_PWR = 8'h00;
  localparam int SRST_BIT = 7;
  localparam int SPWDN_BIT = 0;
  localparam logic [7:0] RST_PWR = 8'h05;
  localparam logic [7:0] RST_SYS = 8'h30;
  localparam logic [7:0] RST_FMT1 = 8'h02;
  localparam logic [7:0] RST_FMT2 = 8'h00;
  localparam logic [7:0] RST_CHSEL = 8'h00;
  localparam logic [7:0] RST_VOL = 8'h40;
  localparam logic [7:0] RST_GAIN = 8'h11;
  localparam logic [7:0] RST_FAULT = 8'h0c;
  localparam int FILT_LEN = 3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_SUB = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_RACK = 3'b101
  } icfg_state_type;
  function automatic logic [7:0] icfg_reset_val(input int idx);
    case (idx)
      0: icfg_reset_val = RST_PWR;
      1: icfg_reset_val = RST_SYS;
      2: icfg_reset_val = RST_FMT1;
      3: icfg_reset_val = RST_FMT2;
      4: icfg_reset_val = RST_CHSEL;
      5: icfg_reset_val = RST_VOL;
      6: icfg_reset_val = RST_GAIN;
      default: icfg_reset_val = RST_FAULT;
    endcase
  endfunction : icfg_reset_val
endpackage : icfg_pkg

// ==== logic/icfg_slave.sv ====
// Two-wire configuration slave with its eight byte-wide control registers.
// Assumes SCL/SDA arrive asynchronously from an external master with pull-ups.
// Assumes the rest of the chip treats o_soft_rst as a chip-wide reset request.
//
// Behaviour
// - Only a target; SDA pulled low only for acks and read data.
// - Responds solely to seven-bit address 0x70, ignores others.
// - First byte is address then direction bit; one reads, zero writes.
// - Start is SDA fall with SCL high; stop is SDA rise.
// - After start, shift eight bits MSB first as address plus direction.
// - Ack address match on ninth pulse; mismatch releases bus, goes idle.
// - Ack each accepted subaddress and write data byte on ninth clock, except a byte that sets the soft reset bit.
// - Subaddress pointer advances by one after each data byte.
// - Stop anywhere out of sequence sends slave to idle; start anywhere reopens the address phase.
// - Invalid subaddress gets no ack and the slave returns idle.
// - Burst read past last register keeps returning the last register.
// - Burst write past last register is discarded, nacked, slave idles.
// - Writing one to bit 7 of register 0x00 resets the chip.
// - Soft reset returns all registers to their defaults.
// - Power-up leaves software power-down set, bus interface still usable.
`timescale 1ns/100ps
module icfg_slave
  import icfg_pkg::*;
#(
  parameter int FILT = FILT_LEN
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Two-wire link pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Register contents and status
  output logic [8*NUM_REGS-1:0] o_regs,
  output logic o_soft_rst,
  output logic o_pwr_down,
  output logic o_busy
);

  // Two-flop synchronisers; first stage read only by the second
  logic [1:0] scl_sync_reg, scl_sync_next;
  logic [1:0] sda_sync_reg, sda_sync_next;
  // Glitch filter state
  logic [FILT-1:0] scl_hist_reg, scl_hist_next;
  logic [FILT-1:0] sda_hist_reg, sda_hist_next;
  logic scl_f_reg, scl_f_next;
  logic sda_f_reg, sda_f_next;
  // Protocol state
  icfg_state_type state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] ptr_reg, ptr_next;
  logic rw_reg, rw_next;
  logic ack_ph_reg, ack_ph_next;
  logic ack_ok_reg, ack_ok_next;
  logic sda_out_reg, sda_out_next;
  logic sda_oe_reg, sda_oe_next;
  logic srst_reg, srst_next;
  logic [7:0] regs_reg [NUM_REGS];
  logic [7:0] regs_next [NUM_REGS];

  logic scl_rise, scl_fall, start_det, stop_det;
  // Byte addressed by the pointer, next to go out on a read
  logic [7:0] cur_byte;

  // Pointer to array index; writes check the range apart first, the read port indexes unchecked
  function automatic logic [2:0] reg_idx(input logic [7:0] ptr);
    reg_idx = ptr[2:0];
  endfunction : reg_idx

  // Filtered lines change only after FILT equal samples
  always_comb begin
    scl_sync_next = {scl_sync_reg[0], i_scl};
    sda_sync_next = {sda_sync_reg[0], i_sda};
    scl_hist_next = {scl_hist_reg[FILT-2:0], scl_sync_reg[1]};
    sda_hist_next = {sda_hist_reg[FILT-2:0], sda_sync_reg[1]};
    scl_f_next = scl_f_reg;
    sda_f_next = sda_f_reg;
    if (&scl_hist_reg) begin
      scl_f_next = 1'b1;
    end else if (~|scl_hist_reg) begin
      scl_f_next = 1'b0;
    end
    if (&sda_hist_reg) begin
      sda_f_next = 1'b1;
    end else if (~|sda_hist_reg) begin
      sda_f_next = 1'b0;
    end
  end

  // Lines reset to their idle-high level, so no false edge follows reset
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_hist_reg <= '1;
      sda_hist_reg <= '1;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
    end else begin
      scl_sync_reg <= scl_sync_next;
      sda_sync_reg <= sda_sync_next;
      scl_hist_reg <= scl_hist_next;
      sda_hist_reg <= sda_hist_next;
      scl_f_reg <= scl_f_next;
      sda_f_reg <= sda_f_next;
    end
  end

  // Edge and condition detection on filtered lines
  assign scl_rise = scl_f_next & ~scl_f_reg;
  assign scl_fall = ~scl_f_next & scl_f_reg;
  assign start_det = scl_f_reg & scl_f_next & sda_f_reg & ~sda_f_next;
  assign stop_det = scl_f_reg & scl_f_next & ~sda_f_reg & sda_f_next;

  // One read port on the register array serves every read byte
  assign cur_byte = regs_reg[reg_idx(ptr_reg)];

  // Protocol engine; SDA changes only after SCL falls, so data is stable while high
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    ack_ph_next = ack_ph_reg;
    ack_ok_next = ack_ok_reg;
    sda_out_next = sda_out_reg;
    sda_oe_next = sda_oe_reg;
    srst_next = 1'b0;
    for (int i = 0; i < NUM_REGS; i++) begin
      regs_next[i] = regs_reg[i];
    end
    if (srst_reg) begin
      // Whole chip back to defaults, power-down included
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_next[i] = icfg_reset_val(i);
      end
      state_next = ST_IDLE;
      sda_oe_next = 1'b0;
      // Protocol state too, so nothing of the cut transfer survives
      shift_next = 8'h00;
      bit_cnt_next = 4'h0;
      ptr_next = 8'h00;
      rw_next = 1'b0;
      ack_ph_next = 1'b0;
      ack_ok_next = 1'b0;
      sda_out_next = 1'b0;
    end else if (start_det) begin
      // Start or repeated start opens a new address phase
      state_next = ST_ADDR;
      bit_cnt_next = 4'h0;
      ack_ph_next = 1'b0;
      sda_oe_next = 1'b0;
    end else if (stop_det) begin
      // A stop anywhere ends the transfer
      state_next = ST_IDLE;
      sda_oe_next = 1'b0;
    end else if (state_reg != ST_IDLE) begin
      if (scl_rise && !ack_ph_reg) begin
        // Count every bit; only receive states shift the line in, since in
        // the read state the shift register holds the outgoing byte
        if (state_reg != ST_RDATA) begin
          shift_next = {shift_reg[6:0], sda_f_reg};
        end
        bit_cnt_next = bit_cnt_reg + 4'h1;
      end else if (scl_rise && ack_ph_reg && state_reg == ST_RACK) begin
        // Master nack ends a read
        if (sda_f_reg) begin
          state_next = ST_IDLE;
        end
      end else if (scl_fall && ack_ph_reg) begin
        // End of ninth clock: release or go on
        ack_ph_next = 1'b0;
        bit_cnt_next = 4'h0;
        sda_oe_next = 1'b0;
        if (!ack_ok_reg) begin
          state_next = ST_IDLE;
        end else if (rw_reg) begin
          // Read direction: put out the next byte's first bit
          state_next = ST_RDATA;
          sda_out_next = cur_byte[7];
          sda_oe_next = ~cur_byte[7];
          shift_next = {cur_byte[6:0], 1'b0};
          if (ptr_reg < LAST_SUB) begin
            ptr_next = ptr_reg + 8'h01;
          end
        end
      end else if (scl_fall && state_reg == ST_RDATA) begin
        if (bit_cnt_reg == 4'h8) begin
          state_next = ST_RACK;
          ack_ph_next = 1'b1;
          ack_ok_next = 1'b1;
          sda_oe_next = 1'b0;
        end else begin
          sda_out_next = shift_reg[7];
          sda_oe_next = ~shift_reg[7];
          shift_next = {shift_reg[6:0], 1'b0};
        end
      end else if (scl_fall && bit_cnt_reg == 4'h8) begin
        // Byte received: decide ack for ninth clock
        ack_ph_next = 1'b1;
        ack_ok_next = 1'b0;
        case (state_reg)
          ST_ADDR: begin
            // Own address: ack, the direction bit picks the path
            if (shift_reg[7:1] == DEV_ADDR) begin
              ack_ok_next = 1'b1;
              rw_next = shift_reg[0];
              state_next = shift_reg[0] ? ST_RDATA : ST_SUB;
            end
          end
          ST_SUB: begin
            // Only existing registers may be addressed
            if (shift_reg <= LAST_SUB) begin
              ack_ok_next = 1'b1;
              ptr_next = shift_reg;
              state_next = ST_WDATA;
            end
          end
          ST_WDATA: begin
            // Store and step; a byte past the last register is dropped
            if (ptr_reg <= LAST_SUB) begin
              ack_ok_next = 1'b1;
              regs_next[reg_idx(ptr_reg)] = shift_reg;
              if (ptr_reg == SUB_PWR && shift_reg[SRST_BIT]) begin
                srst_next = 1'b1;
              end
              ptr_next = ptr_reg + 8'h01;
            end
          end
          default: ack_ok_next = 1'b0;
        endcase
        // Ack pulls low through the ninth clock unless a soft reset follows; a refusal leaves SDA free
        sda_out_next = 1'b0;
        sda_oe_next = ack_ok_next;
        // A foreign address drops straight back to idle
        if (!ack_ok_next && state_reg == ST_ADDR) begin
          state_next = ST_IDLE;
          ack_ph_next = 1'b0;
        end
      end
    end
  end

  // State registers only; every decision is made in the process above
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      ack_ph_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      sda_out_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      srst_reg <= 1'b0;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= icfg_reset_val(i);
      end
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      ack_ph_reg <= ack_ph_next;
      ack_ok_reg <= ack_ok_next;
      sda_out_reg <= sda_out_next;
      sda_oe_reg <= sda_oe_next;
      srst_reg <= srst_next;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= regs_next[i];
      end
    end
  end

  // Register image flattened for the rest of the chip
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_out
      assign o_regs[8*g +: 8] = regs_reg[g];
    end
  endgenerate

  // Outputs come straight from flip-flops, except o_busy, which is decoded from the state register
  assign o_sda_out = sda_out_reg;
  assign o_sda_oe = sda_oe_reg;
  assign o_soft_rst = srst_reg;
  assign o_pwr_down = regs_reg[0][SPWDN_BIT];
  assign o_busy = (state_reg != ST_IDLE);

endmodule : icfg_slave

// ==== tb/icfg_i2c_master.sv ====
// Bus master model: drives SCL and an open-drain SDA, each phase 200 ns.
// Assumes a pull-up on SDA; the slave pulls low through its enable.
`timescale 1ns/100ps
module icfg_i2c_master (
  // Clock and slave drive
  input wire logic i_sys_clk,
  input wire logic i_sda_oe,
  // Link pins
  output logic o_scl,
  output logic o_sda
);
  logic sda_drv = 1'b1;
  // Released line floats high; unknown enable counts as released
  assign o_sda = sda_drv & (i_sda_oe !== 1'b1);
  initial o_scl = 1'b1;
  // Set both pins at a falling edge, then hold
  task automatic pins(input logic c, input logic d, input int n);
    @(negedge i_sys_clk);
    o_scl = c;
    sda_drv = d;
    repeat (n - 1) @(negedge i_sys_clk);
  endtask : pins
  // Data moves only while SCL is low, so no stray condition
  task automatic bit_x(input logic b, output logic r);
    pins(1'b0, sda_drv, 2);
    pins(1'b0, b, 6);
    pins(1'b1, b, 4);
    r = o_sda;
    pins(1'b1, b, 4);
  endtask : bit_x
  // Start or repeated start, one per SCL high
  task automatic start_x();
    pins(1'b0, sda_drv, 2);
    pins(1'b0, 1'b1, 6);
    pins(1'b1, 1'b1, 8);
    pins(1'b1, 1'b0, 8);
  endtask : start_x
  // Every transfer ends here
  task automatic stop_x();
    pins(1'b0, sda_drv, 2);
    pins(1'b0, 1'b0, 6);
    pins(1'b1, 1'b0, 8);
    pins(1'b1, 1'b1, 8);
  endtask : stop_x
  // Byte MSB first, then the ninth bit a from the master
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(a, r);
    ack = !r;
  endtask : xfer
endmodule : icfg_i2c_master

// ==== tb/icfg_slave_assertions.sv ====
// Concurrent checks on the configuration slave's pins and register image.
// Assumes binding to icfg_slave; sees only its ports.
`timescale 1ns/100ps
module icfg_slave_assertions
  import icfg_pkg::*;
#(
  parameter int FILT = FILT_LEN
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Pins and status
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic [8*NUM_REGS-1:0] o_regs,
  input wire logic o_soft_rst,
  input wire logic o_pwr_down,
  input wire logic o_busy
);
  localparam logic [63:0] IMAGE = {RST_FAULT, RST_GAIN, RST_VOL, RST_CHSEL, RST_FMT2,
    RST_FMT1, RST_SYS, RST_PWR};
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  // Raw pin conditions; the filter delay is allowed for below
  sequence seq_start;
    i_scl && $fell(i_sda);
  endsequence
  sequence seq_stop;
    i_scl && $rose(i_sda);
  endsequence
  a_oe_drives_low: assert property (o_sda_oe |-> !o_sda_out) else $error("sda driven high");
  a_idle_quiet: assert property (!o_busy [*2] |-> !o_sda_oe) else $error("sda pulled in idle");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl) else $error("sda moved, scl high");
  a_start_busy: assert property (seq_start |-> ##[3:12] o_busy) else $error("start missed");
  a_stop_idle: assert property (seq_stop |-> ##[3:12] !o_busy) else $error("stop missed");
  a_rst_image: assert property ($fell(i_rst) |-> o_regs == IMAGE && !o_busy && o_pwr_down)
    else $error("bad reset state");
  a_soft_image: assert property (o_soft_rst |=> o_regs == IMAGE) else $error("soft reset");
  a_soft_pulse: assert property (o_soft_rst |=> !o_soft_rst) else $error("long soft pulse");
  a_regs_idle: assert property (!o_busy && !o_soft_rst |=> $stable(o_regs))
    else $error("regs moved in idle");
endmodule : icfg_slave_assertions
bind icfg_slave icfg_slave_assertions #(.FILT(FILT)) icfg_slave_assertions_inst (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_regs(o_regs), .o_soft_rst(o_soft_rst), .o_pwr_down(o_pwr_down),
  .o_busy(o_busy));

// ==== tb/icfg_slave_tb_top.sv ====
// Testbench: bursts, refusals, aborts and soft reset on the slave.
// Assumes the master model and the package constants.
`timescale 1ns/100ps
module icfg_slave_tb_top;
  import icfg_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic scl, sda, sda_out, sda_oe, soft_rst, pwr_down, busy;
  int srst_count = 0;
  logic [63:0] regs;
  logic [7:0] exp_r [NUM_REGS];
  int fail_count = 0;
  int comparisons = 0;
  // 40 MHz clock; soft reset pulses are counted, so a long pulse shows too
  always #12.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (soft_rst === 1'b1) srst_count <= srst_count + 1;
  icfg_i2c_master icfg_i2c_master_inst (.i_sys_clk(i_sys_clk), .i_sda_oe(sda_oe), .o_scl(scl),
    .o_sda(sda));
  icfg_slave #(.FILT(FILT_LEN)) icfg_slave_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_regs(regs),
    .o_soft_rst(soft_rst), .o_pwr_down(pwr_down), .o_busy(busy));
  task automatic chk1(input string w, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", w, e, g);
    end
  endtask : chk1
  task automatic chk64(input string w, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask : chk64
  function automatic logic [63:0] image();
    for (int i = 0; i < NUM_REGS; i++) image[8*i +: 8] = exp_r[i];
  endfunction : image
  task automatic conclude();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // Each test ends with the slave idle and the image as predicted
  task automatic finish_test(input string name);
    chk1("busy", 1'b0, busy);
    chk64("regs", image(), regs);
    $display("test %s done", name);
  endtask : finish_test
  task automatic addr(input logic [7:0] a, input logic e);
    logic [7:0] q;
    logic ack;
    icfg_i2c_master_inst.start_x();
    icfg_i2c_master_inst.xfer(a, 1'b1, q, ack);
    chk1("address ack", e, ack);
  endtask : addr
  // Burst write; a byte past the last register is refused
  task automatic wr(input logic [7:0] sub, input int n, input logic [7:0] d0);
    logic [7:0] q, d;
    logic ack;
    addr(8'he0, 1'b1);
    icfg_i2c_master_inst.xfer(sub, 1'b1, q, ack);
    chk1("sub ack", sub <= LAST_SUB, ack);
    for (int k = 0; k < n && sub <= LAST_SUB; k++) begin
      d = (k == 0) ? d0 : 8'($urandom);
      icfg_i2c_master_inst.xfer(d, 1'b1, q, ack);
      if (sub != SUB_PWR || !d0[SRST_BIT]) chk1("data ack", sub + k <= LAST_SUB, ack);
      if (sub + k <= LAST_SUB) exp_r[sub + k] = d;
    end
    icfg_i2c_master_inst.stop_x();
  endtask : wr
  // Read after repeated start; pointer sticks at the last register
  task automatic rd(input logic [7:0] sub, input int n);
    logic [7:0] q;
    logic ack;
    addr(8'he0, 1'b1);
    icfg_i2c_master_inst.xfer(sub, 1'b1, q, ack);
    addr(8'he1, 1'b1);
    for (int k = 0; k < n; k++) begin
      icfg_i2c_master_inst.xfer(8'hff, k == n - 1, q, ack);
      chk64("read byte", 64'(exp_r[(sub + k > 7) ? 7 : sub + k]), 64'(q));
    end
    icfg_i2c_master_inst.stop_x();
  endtask : rd
  initial begin
    logic [7:0] q;
    logic ack;
    int srst_base;
    exp_r = '{RST_PWR, RST_SYS, RST_FMT1, RST_FMT2, RST_CHSEL, RST_VOL, RST_GAIN, RST_FAULT};
    void'($urandom(32'hc513));
    repeat (6) @(negedge i_sys_clk);
    i_rst = 1'b0;
    repeat (8) @(negedge i_sys_clk);
    chk1("power down", 1'b1, pwr_down);
    finish_test("reset");
    for (int t = 0; t < 6; t++) begin
      wr(8'($urandom_range(7, 1)), int'($urandom_range(3, 1)), 8'($urandom));
      rd(8'($urandom_range(7, 0)), int'($urandom_range(3, 1)));
      finish_test("random");
    end
    wr(8'h06, 3, 8'h5a);
    rd(8'h05, 5);
    finish_test("boundary");
    wr(8'($urandom_range(255, 8)), 1, 8'h00);
    addr({DEV_ADDR ^ 7'($urandom_range(127, 1)), 1'b0}, 1'b0);
    icfg_i2c_master_inst.xfer(8'h01, 1'b1, q, ack);
    chk1("foreign ack", 1'b0, ack);
    icfg_i2c_master_inst.stop_x();
    addr(8'he0, 1'b1);
    icfg_i2c_master_inst.xfer(8'h02, 1'b1, q, ack);
    for (int i = 0; i < 4; i++) icfg_i2c_master_inst.bit_x(1'b0, ack);
    icfg_i2c_master_inst.stop_x();
    finish_test("refusals");
    wr(SUB_PWR, 1, 8'h04);
    chk1("power down", 1'b0, pwr_down);
    srst_base = srst_count;
    wr(SUB_PWR, 1, 8'h80);
    exp_r = '{RST_PWR, RST_SYS, RST_FMT1, RST_FMT2, RST_CHSEL, RST_VOL, RST_GAIN, RST_FAULT};
    chk1("soft reset", 1'b1, srst_count == srst_base + 1);
    finish_test("soft reset");
    conclude();
  end
  // Watchdog cuts a hang short
  initial begin
    repeat (100000) @(posedge i_sys_clk);
    fail_count++;
    conclude();
  end
endmodule : icfg_slave_tb_top
